/* rtl/bidir_port_pins.sv */
// Top of the bidirectional port block: registers, read path, pads, synchroniser.
// Assumes a plain register port whose strobes are one cycle long and never together.
//
// Our own choices: the address map and the plain strobed port.
`timescale 1ns/10ps
`default_nettype none
`include "gpio_consts.svh"
module bidir_port_pins
	import gpio_pkg::*;
(
	// Clock and reset
	input wire logic clock,
	input wire logic rstn,
	// Register port
	input wire logic [7:0] addr,
	input wire logic [7:0] wdata,
	input wire logic we,
	input wire logic re,
	output logic [7:0] rdata,
	// Single-bit operations
	input wire logic bit_set,
	input wire logic bit_clr,
	input wire logic [2:0] bit_index,
	// Alternate function override
	input wire logic [`GPIO_PINS-1:0] alt_enable,
	input wire logic [`GPIO_PINS-1:0] alt_oe,
	input wire logic [`GPIO_PINS-1:0] alt_out,
	// Pads
	input wire logic [`GPIO_PINS-1:0] pad_in,
	output logic [`GPIO_PINS-1:0] pad_out,
	output logic [`GPIO_PINS-1:0] pad_oe_n,
	output logic [`GPIO_PINS-1:0] pad_pullup,
	// Pull-up disable level
	output logic global_pullup_disable
);
	byte_t dir_q [`GPIO_PORTS];
	byte_t out_q [`GPIO_PORTS];
	byte_t dir_d [`GPIO_PORTS];
	byte_t out_d [`GPIO_PORTS];
	logic pullup_off_q;
	logic pullup_off_d;
	byte_t rdata_q;
	byte_t rdata_d;
	logic [`GPIO_PINS-1:0] sample_q;
	logic [`GPIO_PINS-1:0] dir_flat;
	logic [`GPIO_PINS-1:0] out_flat;
	reg_kind_t acc_kind;
	logic [1:0] acc_port;

	// Which register an address names
	function automatic reg_kind_t kind_of(input logic [7:0] a);
		reg_kind_t k;
		k = kind_none;
		if (a == `OFS_SFIO) begin
			k = kind_sfio;
		end
		for (int p = 0; p < `GPIO_PORTS; p++) begin
			if (a == 8'(p) * `GPIO_STRIDE + `OFS_INPUT) begin
				k = kind_input;
			end
			if (a == 8'(p) * `GPIO_STRIDE + `OFS_DIR) begin
				k = kind_dir;
			end
			if (a == 8'(p) * `GPIO_STRIDE + `OFS_OUT) begin
				k = kind_out;
			end
		end
		return k;
	endfunction

	// Which port an address names
	function automatic logic [1:0] port_of(input logic [7:0] a);
		logic [1:0] n;
		n = 2'h0;
		for (int p = 0; p < `GPIO_PORTS; p++) begin
			if (a >= 8'(p) * `GPIO_STRIDE && a < 8'(p + 1) * `GPIO_STRIDE) begin
				n = 2'(p);
			end
		end
		return n;
	endfunction

	// Next value of one port register
	function automatic byte_t next_byte(input byte_t cur, input logic hit, input logic wr,
		input logic set, input logic clr, input logic [2:0] idx, input byte_t wd);
		byte_t v;
		v = cur;
		if (hit && wr) begin
			v = wd;
		end else if (hit && set) begin
			v = cur | (8'h01 << idx);
		end else if (hit && clr) begin
			v = cur & ~(8'h01 << idx);
		end
		return v;
	endfunction

	assign acc_kind = kind_of(addr);
	assign acc_port = port_of(addr);

	// Next register values
	always_comb begin
		for (int p = 0; p < `GPIO_PORTS; p++) begin
			dir_d[p] = next_byte(dir_q[p], acc_kind == kind_dir && acc_port == 2'(p),
				we, bit_set, bit_clr, bit_index, wdata);
			out_d[p] = next_byte(out_q[p], acc_kind == kind_out && acc_port == 2'(p),
				we, bit_set, bit_clr, bit_index, wdata);
		end
	end

	always_comb begin
		pullup_off_d = pullup_off_q;
		if (acc_kind == kind_sfio) begin
			if (we) begin
				pullup_off_d = wdata[`PULLUP_OFF_BIT];
			end else if (bit_set && bit_index == 3'(`PULLUP_OFF_BIT)) begin
				pullup_off_d = 1'b1;
			end else if (bit_clr && bit_index == 3'(`PULLUP_OFF_BIT)) begin
				pullup_off_d = 1'b0;
			end
		end
	end

	// Direction registers
	always_ff @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			for (int p = 0; p < `GPIO_PORTS; p++) begin
				dir_q[p] <= `RST_DIR;
			end
		end else begin
			for (int p = 0; p < `GPIO_PORTS; p++) begin
				dir_q[p] <= dir_d[p];
			end
		end
	end

	// Output registers
	always_ff @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			for (int p = 0; p < `GPIO_PORTS; p++) begin
				out_q[p] <= `RST_OUT;
			end
		end else begin
			for (int p = 0; p < `GPIO_PORTS; p++) begin
				out_q[p] <= out_d[p];
			end
		end
	end

	// Global pull-up disable
	always_ff @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			pullup_off_q <= `RST_PULLUP_OFF;
		end else begin
			pullup_off_q <= pullup_off_d;
		end
	end

	assign global_pullup_disable = pullup_off_q;

	// Read data, one cycle after the strobe
	always_comb begin
		rdata_d = 8'h00;
		if (re) begin
			case (acc_kind)
				kind_input: rdata_d = sample_q[acc_port * 8 +: 8];
				kind_dir: rdata_d = dir_q[acc_port];
				kind_out: rdata_d = out_q[acc_port];
				kind_sfio: rdata_d = 8'(pullup_off_q) << `PULLUP_OFF_BIT;
				default: rdata_d = 8'h00;
			endcase
		end
	end

	always_ff @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			rdata_q <= 8'h00;
		end else begin
			rdata_q <= rdata_d;
		end
	end

	assign rdata = rdata_q;

	// Bit n of the port p registers is pin p * 8 + n
	always_comb begin
		for (int p = 0; p < `GPIO_PORTS; p++) begin
			dir_flat[p * 8 +: 8] = dir_q[p];
			out_flat[p * 8 +: 8] = out_q[p];
		end
	end

	pad_ctrl u_pad (
		.rstn(rstn),
		.dir(dir_flat),
		.out(out_flat),
		.pullup_off(pullup_off_q),
		.alt_enable(alt_enable),
		.alt_oe(alt_oe),
		.alt_out(alt_out),
		.pad_out(pad_out),
		.pad_oe_n(pad_oe_n),
		.pad_pullup(pad_pullup)
	);

	pin_sync u_sync (
		.clock(clock),
		.rstn(rstn),
		.pad_in(pad_in),
		.sample_q(sample_q)
	);

	// Checks
	sequence wr_dir_s;
		we && acc_kind == kind_dir;
	endsequence

	sequence set_dir_s;
		!we && bit_set && acc_kind == kind_dir;
	endsequence

	sequence clr_out_s;
		!we && !bit_set && bit_clr && acc_kind == kind_out;
	endsequence

	sequence rd_input_s;
		re && acc_kind == kind_input;
	endsequence

	sequence wr_out_s;
		we && acc_kind == kind_out;
	endsequence

	sequence set_out_s;
		!we && bit_set && acc_kind == kind_out;
	endsequence

	sequence clr_dir_s;
		!we && !bit_set && bit_clr && acc_kind == kind_dir;
	endsequence

	sequence rd_dir_s;
		re && acc_kind == kind_dir;
	endsequence

	sequence rd_out_s;
		re && acc_kind == kind_out;
	endsequence

	sequence wr_flag_s;
		we && acc_kind == kind_sfio;
	endsequence

	dir_drive_a: assert property (@(posedge clock) disable iff (!rstn)
		pad_oe_n == ~((alt_enable & alt_oe) | (~alt_enable & dir_flat)))
		else $error("pad enable does not follow direction");

	pullup_on_a: assert property (@(posedge clock) disable iff (!rstn)
		pad_pullup == (~alt_enable & ~dir_flat & out_flat & {`GPIO_PINS{~pullup_off_q}}))
		else $error("pull-up state wrong");

	reset_tristate_a: assert property (@(posedge clock)
		!rstn |-> (&pad_oe_n) && pad_pullup == '0)
		else $error("pins not tri-state under reset");

	drive_level_a: assert property (@(posedge clock) disable iff (!rstn)
		(pad_out & ~alt_enable) == (out_flat & ~alt_enable))
		else $error("driven level differs from output bit");

	pullup_kill_a: assert property (@(posedge clock) disable iff (!rstn)
		pullup_off_q |-> pad_pullup == '0)
		else $error("pull-up on while globally disabled");

	dir_write_a: assert property (@(posedge clock) disable iff (!rstn)
		wr_dir_s |=> dir_q[$past(acc_port)] == $past(wdata))
		else $error("direction write lost");

	input_read_a: assert property (@(posedge clock) disable iff (!rstn)
		rd_input_s |=> rdata == $past(sample_q[acc_port * 8 +: 8]))
		else $error("input read does not return sample");

	write_readback_a: assert property (@(posedge clock) disable iff (!rstn)
		wr_out_s ##1 1'b1 |=> ((sample_q ^ $past(pad_out)) & ~$past(pad_oe_n)) == '0)
		else $error("written pin level not sampled one cycle later");

	bit_set_a: assert property (@(posedge clock) disable iff (!rstn)
		set_dir_s |=> dir_q[$past(acc_port)] == ($past(dir_q[acc_port]) | (8'h01 << $past(bit_index))))
		else $error("bit set disturbed other pins");

	bit_clear_a: assert property (@(posedge clock) disable iff (!rstn)
		clr_out_s |=> out_q[$past(acc_port)] == ($past(out_q[acc_port]) & ~(8'h01 << $past(bit_index))))
		else $error("bit clear disturbed other pins");

	input_readonly_a: assert property (@(posedge clock) disable iff (!rstn)
		(we && acc_kind == kind_input) |=> dir_flat == $past(dir_flat) && out_flat == $past(out_flat))
		else $error("write to input register changed state");

	alt_isolated_a: assert property (@(posedge clock) disable iff (!rstn)
		(pad_oe_n & ~alt_enable) == (~dir_flat & ~alt_enable))
		else $error("alternate function leaked into plain pins");

	unmapped_read_a: assert property (@(posedge clock) disable iff (!rstn)
		(re && acc_kind == kind_none) |=> rdata == 8'h00)
		else $error("unmapped read not zero");

	out_write_a: assert property (@(posedge clock) disable iff (!rstn)
		wr_out_s |=> out_q[$past(acc_port)] == $past(wdata))
		else $error("output write lost");

	dir_read_a: assert property (@(posedge clock) disable iff (!rstn)
		rd_dir_s |=> rdata == $past(dir_q[acc_port]))
		else $error("direction read wrong");

	out_read_a: assert property (@(posedge clock) disable iff (!rstn)
		rd_out_s |=> rdata == $past(out_q[acc_port]))
		else $error("output read wrong");

	rdata_idle_a: assert property (@(posedge clock) disable iff (!rstn)
		!re |=> rdata == 8'h00)
		else $error("read data not zero without a read");

	pullup_write_a: assert property (@(posedge clock) disable iff (!rstn)
		wr_flag_s |=> pullup_off_q == $past(wdata[`PULLUP_OFF_BIT]))
		else $error("pull-up disable write lost");

	driven_no_pullup_a: assert property (@(posedge clock) disable iff (!rstn)
		(pad_pullup & dir_flat) == '0)
		else $error("pull-up on a driven pin");

	bit_set_out_a: assert property (@(posedge clock) disable iff (!rstn)
		set_out_s |=> out_q[$past(acc_port)] == ($past(out_q[acc_port]) | (8'h01 << $past(bit_index))))
		else $error("output bit set wrong");

	bit_clear_dir_a: assert property (@(posedge clock) disable iff (!rstn)
		clr_dir_s |=> dir_q[$past(acc_port)] == ($past(dir_q[acc_port]) & ~(8'h01 << $past(bit_index))))
		else $error("direction bit clear wrong");

	set_other_a: assert property (@(posedge clock) disable iff (!rstn)
		set_dir_s |=> ((dir_flat ^ $past(dir_flat))
			& ~(24'h000001 << ($past(acc_port) * 8 + $past(bit_index)))) == '0)
		else $error("bit set touched another pin");

	clear_other_a: assert property (@(posedge clock) disable iff (!rstn)
		clr_out_s |=> ((out_flat ^ $past(out_flat))
			& ~(24'h000001 << ($past(acc_port) * 8 + $past(bit_index)))) == '0)
		else $error("bit clear touched another pin");
endmodule // bidir_port_pins
`default_nettype wire

/* rtl/gpio_consts.svh */
// Constants of the bidirectional port block: offsets, field positions, reset values.
// Assumes inclusion by bare name from the design modules and the testbench.
//
// Function
// - A pin drives out when its direction bit is one and is an input when it is zero.
// - An input pin has its pull-up on when its output bit is one, off when that bit is zero or the pin is an output.
// - All pins are tri-state while reset is active, with or without a running clock.
// - An output pin drives its output bit value, high or low, whatever the global pull-up disable says.
// - The global pull-up disable turns off every pull-up, leaving such inputs tri-state.
// - Each port has a read/write output register, a read/write direction register and a read-only input register.
// - The input register returns the synchronised pin level whatever the direction bit.
// - The synchroniser is a latch open while the clock is high feeding a flop loaded on the next rising edge.
// - An external pin change reaches the input register after one half to one and a half clock periods.
// - A pin value written by software reaches the input register exactly one clock period after the write edge.
// - Single-bit set and clear leave every other pin of the port unchanged.
// - Pins given to an alternate function leave the other pins of the port usable as plain I/O.
`ifndef GPIO_CONSTS_SVH
`define GPIO_CONSTS_SVH

`define GPIO_PORTS 3
`define GPIO_WIDTH 8
`define GPIO_PINS 24
`define GPIO_STRIDE 8'h03
`define OFS_INPUT 8'h00
`define OFS_DIR 8'h01
`define OFS_OUT 8'h02
`define OFS_SFIO 8'h0f
`define PULLUP_OFF_BIT 2
`define RST_DIR 8'h00
`define RST_OUT 8'h00
`define RST_PULLUP_OFF 1'b0
`define CLK_PERIOD_NS 10

`endif

/* rtl/gpio_pkg.sv */
// Types shared by the port block.
// Assumes the constants header sits beside it.
package gpio_pkg;
	typedef logic [7:0] byte_t;
	typedef enum {kind_input, kind_dir, kind_out, kind_sfio, kind_none} reg_kind_t;
endpackage

/* rtl/pin_sync.sv */
// Latch plus flop input synchroniser for all pins.
// Assumes pad levels arrive asynchronously to clock.
`timescale 1ns/10ps
`default_nettype none
`include "gpio_consts.svh"
module pin_sync (
	// Clock and reset
	input wire logic clock,
	input wire logic rstn,
	// Pads in, samples out
	input wire logic [`GPIO_PINS-1:0] pad_in,
	output logic [`GPIO_PINS-1:0] sample_q
);
	logic [`GPIO_PINS-1:0] latch_q;

	// Open while clock high, holds while low
	always_latch begin
		if (clock) begin
			latch_q <= pad_in;
		end
	end

	always_ff @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			sample_q <= '0;
		end else begin
			sample_q <= latch_q;
		end
	end

	sync_load_a: assert property (@(posedge clock) disable iff (!rstn)
		##1 sample_q == $past(latch_q)) else $error("sync flop missed latch value");
endmodule // pin_sync
`default_nettype wire

/* rtl/pad_ctrl.sv */
// Pad drive, enable and pull-up per pin, with alternate function override.
// Assumes the enable is low while the pad is driven.
`timescale 1ns/10ps
`default_nettype none
`include "gpio_consts.svh"
module pad_ctrl (
	// Reset, acts without clock
	input wire logic rstn,
	// Register state
	input wire logic [`GPIO_PINS-1:0] dir,
	input wire logic [`GPIO_PINS-1:0] out,
	input wire logic pullup_off,
	// Alternate function
	input wire logic [`GPIO_PINS-1:0] alt_enable,
	input wire logic [`GPIO_PINS-1:0] alt_oe,
	input wire logic [`GPIO_PINS-1:0] alt_out,
	// Pads
	output logic [`GPIO_PINS-1:0] pad_out,
	output logic [`GPIO_PINS-1:0] pad_oe_n,
	output logic [`GPIO_PINS-1:0] pad_pullup
);
	logic [`GPIO_PINS-1:0] drive;
	logic [`GPIO_PINS-1:0] value;
	logic [`GPIO_PINS-1:0] run;

	assign run = {`GPIO_PINS{rstn}};
	// Override only where enabled
	assign drive = (alt_enable & alt_oe) | (~alt_enable & dir);
	assign value = (alt_enable & alt_out) | (~alt_enable & out);
	// Tri-state under reset
	assign pad_oe_n = ~(drive & run);
	assign pad_out = value & run;
	assign pad_pullup = ~alt_enable & ~dir & out & {`GPIO_PINS{~pullup_off}} & run;
endmodule // pad_ctrl
`default_nettype wire

/* dv/pad_partner.sv */
// Model of the circuitry on the port pads: resolves each pad level.
// Assumes pad_oe_n low while the block drives; floating pads wander.
`timescale 1ns/10ps
`default_nettype none
`include "gpio_consts.svh"
module pad_partner (
	// Clock for the floating pattern
	input wire logic clock,
	// Block side of the pads
	input wire logic [`GPIO_PINS-1:0] pad_out,
	input wire logic [`GPIO_PINS-1:0] pad_oe_n,
	input wire logic [`GPIO_PINS-1:0] pad_pullup,
	// External drivers
	input wire logic [`GPIO_PINS-1:0] ext_en,
	input wire logic [`GPIO_PINS-1:0] ext_val,
	// Resolved level
	output logic [`GPIO_PINS-1:0] pad_in
);
	logic [`GPIO_PINS-1:0] last_q = '0;
	always @(posedge clock) begin
		last_q <= pad_in;
	end
	always_comb begin
		for (int i = 0; i < `GPIO_PINS; i++) begin
			if (!pad_oe_n[i])
				pad_in[i] = pad_out[i];
			else if (ext_en[i])
				pad_in[i] = ext_val[i];
			else if (pad_pullup[i])
				pad_in[i] = 1'b1;
			else
				pad_in[i] = ~last_q[i];
		end
	end
endmodule // pad_partner
`default_nettype wire

/* dv/bidir_port_pins_tb_top.sv */
// Testbench of the port block: register tasks, pad model, checks.
// Assumes the address map and strobes of the block's register port.
`timescale 1ns/10ps
`default_nettype none
`include "gpio_consts.svh"
module bidir_port_pins_tb_top;
	import gpio_pkg::*;
	logic clock = 1'b0;
	logic run = 1'b1;
	logic rstn = 1'b0;
	logic [7:0] addr = 8'h00;
	logic [7:0] wdata = 8'h00;
	logic we = 1'b0, re = 1'b0, bit_set = 1'b0, bit_clr = 1'b0;
	logic [2:0] bit_index = 3'h0;
	logic [`GPIO_PINS-1:0] alt_enable = '0, alt_oe = '0, alt_out = '0, ext_en = '0, ext_val = '0;
	logic [`GPIO_PINS-1:0] pad_in, pad_out, pad_oe_n, pad_pullup;
	logic [7:0] rdata;
	logic gpd;
	int error_cnt = 0;
	int check_count = 0;

	always #5 clock = run ? ~clock : clock;

	bidir_port_pins uut (.clock(clock), .rstn(rstn), .addr(addr), .wdata(wdata), .we(we), .re(re),
		.rdata(rdata), .bit_set(bit_set), .bit_clr(bit_clr), .bit_index(bit_index),
		.alt_enable(alt_enable), .alt_oe(alt_oe), .alt_out(alt_out), .pad_in(pad_in),
		.pad_out(pad_out), .pad_oe_n(pad_oe_n), .pad_pullup(pad_pullup), .global_pullup_disable(gpd));
	pad_partner pads (.clock(clock), .pad_out(pad_out), .pad_oe_n(pad_oe_n), .pad_pullup(pad_pullup),
		.ext_en(ext_en), .ext_val(ext_val), .pad_in(pad_in));

	task automatic chk(input string what, input logic [23:0] seen, input logic [23:0] exp);
		check_count++;
		if (seen !== exp) begin
			error_cnt++;
			$display("[FAIL] %s expected %h seen %h", what, exp, seen);
		end
	endtask
	task automatic wr(input byte_t a, input byte_t d);
		@(posedge clock);
		addr <= a;
		wdata <= d;
		we <= 1'b1;
		@(posedge clock);
		we <= 1'b0;
	endtask
	task automatic rchk(input string what, input byte_t a, input byte_t exp);
		@(posedge clock);
		addr <= a;
		re <= 1'b1;
		@(posedge clock);
		re <= 1'b0;
		#1 chk(what, {16'h0000, rdata}, {16'h0000, exp});
	endtask
	task automatic bop(input logic s, input byte_t a, input logic [2:0] i);
		@(posedge clock);
		addr <= a;
		bit_index <= i;
		bit_set <= s;
		bit_clr <= !s;
		@(posedge clock);
		bit_set <= 1'b0;
		bit_clr <= 1'b0;
	endtask
	task automatic pads_chk(input logic [23:0] oe_n, input logic [23:0] drv, input logic [23:0] pu);
		#1 chk("pad_oe_n", pad_oe_n, oe_n);
		chk("driven pads", pad_out & ~pad_oe_n, drv);
		chk("pad_pullup", pad_pullup, pu);
	endtask
	task automatic close_out();
		$display("checks %0d mismatches %0d", check_count, error_cnt);
		if (error_cnt == 0 && check_count > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask

	initial begin
		repeat (6) @(posedge clock);
		rstn <= 1'b1;
		pads_chk(24'hffffff, 24'h000000, 24'h000000);
		for (int p = 0; p < 3; p++) begin
			rchk("dir reset", 8'(3 * p + 1), `RST_DIR);
			rchk("out reset", 8'(3 * p + 2), `RST_OUT);
		end
		rchk("sfio reset", `OFS_SFIO, 8'h00);
		$display("test reset done");
		wr(8'h05, 8'hc3);
		wr(8'h04, 8'h0f);
		pads_chk(24'hfff0ff, 24'h000300, 24'h00c000);
		rchk("dir port1", 8'h04, 8'h0f);
		rchk("out port1", 8'h05, 8'hc3);
		wr(8'h03, 8'h55);
		rchk("dir after input write", 8'h04, 8'h0f);
		@(posedge clock);
		ext_en <= 24'h003000;
		ext_val <= 24'h002000;
		rchk("input port1", 8'h03, 8'he3);
		@(posedge clock);
		ext_val <= 24'h001000;
		rchk("input after pin change", 8'h03, 8'hd3);
		$display("test direction and input done");
		wr(8'h01, 8'hff);
		wr(8'h02, 8'h5a);
		rchk("input readback", 8'h00, 8'h5a);
		wr(`OFS_SFIO, 8'h04);
		pads_chk(24'hfff000, 24'h00035a, 24'h000000);
		chk("pullup disable", {23'h0, gpd}, 24'h000001);
		rchk("sfio", `OFS_SFIO, 8'h04);
		wr(`OFS_SFIO, 8'h00);
		pads_chk(24'hfff000, 24'h00035a, 24'h00c000);
		bop(1'b1, `OFS_SFIO, 3'(`PULLUP_OFF_BIT));
		#1 chk("pullup disable bit set", {23'h0, gpd}, 24'h000001);
		bop(1'b0, `OFS_SFIO, 3'(`PULLUP_OFF_BIT));
		#1 chk("pullup disable bit clear", {23'h0, gpd}, 24'h000000);
		$display("test pull-up disable done");
		bop(1'b1, 8'h07, 3'd3);
		rchk("dir port2 bit set", 8'h07, 8'h08);
		bop(1'b0, 8'h05, 3'd0);
		rchk("out port1 bit clear", 8'h05, 8'hc2);
		pads_chk(24'hf7f000, 24'h00025a, 24'h00c000);
		bop(1'b1, 8'h08, 3'd0);
		pads_chk(24'hf7f000, 24'h00025a, 24'h01c000);
		bop(1'b1, 8'h07, 3'd0);
		pads_chk(24'hf6f000, 24'h01025a, 24'h00c000);
		bop(1'b0, 8'h08, 3'd0);
		pads_chk(24'hf6f000, 24'h00025a, 24'h00c000);
		bop(1'b0, 8'h07, 3'd0);
		pads_chk(24'hf7f000, 24'h00025a, 24'h00c000);
		$display("test bit operations done");
		@(posedge clock);
		alt_enable <= 24'h004000;
		alt_oe <= 24'h004000;
		alt_out <= 24'h004000;
		@(posedge clock);
		pads_chk(24'hf7b000, 24'h00425a, 24'h008000);
		rchk("unmapped read", 8'h20, 8'h00);
		$display("test alternate function done");
		run = 1'b0;
		#3 rstn <= 1'b0;
		pads_chk(24'hffffff, 24'h000000, 24'h000000);
		chk("pad_out in reset", pad_out, 24'h000000);
		$display("test reset without clock done");
		close_out();
	end
endmodule // bidir_port_pins_tb_top
`default_nettype wire
